// ---- hw/pucfg_header.sv ----
// Configuration header registers 08h to 80h of the UART function
`default_nettype none
// Operation
// [R01] Class dword returns programming interface 02h, sub-class 00h, base class 07h.
// [R02] Cache line size is read/write, resets to 00h, steers nothing.
// [R03] Latency timer bits 15:8 always read zero, writes ignored.
// [R04] Header type bits 23:16 always read 00h.
// [R05] First base address claims 64-byte I/O window, resets 00000001h.
// [R06] Second base address claims 4096-byte memory window, resets zero.
// [R07] Subsystem vendor identifier is read-only, default replaceable by autoload.
// [R08] Subsystem device identifier is read-only, default replaceable by autoload.
// [R09] Capabilities pointer reads 80h by default, autoload may replace it.
// [R10] Interrupt line is read/write, resets 00h; host firmware programs routing.
// [R11] Interrupt pin reads 01h.
// [R12] Power management capability identifier reads 01h.
// [R13] Next capability pointer reads 8Ch.
// [R14] Power management revision field reads 011b.
// [R15] Event clock bit reads zero.
// [R16] Auxiliary power bit reads one.
// [R17] Device specific initialization reads zero by default, autoload may override.
// [R18] Auxiliary current reads 111b by default, autoload may override.
// [R19] D1 and D2 support bits read one, each autoload overridable.
// [R20] Wake support pattern reads 01000b by default, autoload may override.
// [R21] Writes to read-only fields leave their value unchanged.
// [R22] Base bits below window size stay fixed, so sizing probes show size.
module pucfg_header
    import pucfg_pkg::*;
#(
    parameter logic [15:0] SUBSYS_VENDOR_INIT = SUBSYS_VENDOR_DEFAULT,
    parameter logic [15:0] SUBSYS_DEVICE_INIT = SUBSYS_DEVICE_DEFAULT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Configuration access from the link core, one dword per request
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    // EEPROM autoload, one-cycle strobes from the loader
    input wire logic loadSubsys,
    input wire logic [31:0] loadSubsysData,
    input wire logic loadCapPtr,
    input wire logic [7:0] loadCapPtrData,
    input wire logic loadPmCap,
    input wire logic [PMC_WIDTH-1:0] loadPmCapData,
    // Decoded state for the rest of the function
    output logic [31:0] ioWindowBase,
    output logic [31:0] memWindowBase,
    output logic [7:0] interruptLine
);
    logic [7:0] cacheLine_reg;
    logic [7:0] intLine_reg;
    logic [31:0] ioBar_reg;
    logic [31:0] memBar_reg;
    logic [31:0] subsys_reg;
    logic [7:0] capPtr_reg;
    logic [PMC_WIDTH-1:0] pmCap_reg;
    logic [31:0] rdData_reg;
    logic rdValid_reg;

    // Byte-lane merge, used for every writable dword
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Autoload defaults; the fixed bits 16 to 20 come from constants only
    localparam logic [PMC_WIDTH-1:0] PMC_RESET = {PMC_WAKE_DEFAULT, PMC_D2_DEFAULT,
        PMC_D1_DEFAULT, PMC_AUX_CURRENT_DEFAULT, PMC_DSI_DEFAULT, PMC_AUX_POWER,
        PMC_EVENT_CLOCK, PMC_REVISION};

    wire logic hitMisc = cfgWrite && (cfgAddr == OFF_MISC);
    wire logic hitIoBar = cfgWrite && (cfgAddr == OFF_IOBAR);
    wire logic hitMemBar = cfgWrite && (cfgAddr == OFF_MEMBAR);
    wire logic hitIntr = cfgWrite && (cfgAddr == OFF_INTR);

    wire logic [31:0] miscMerged = lane_merge({24'h000000, cacheLine_reg}, cfgWrData, cfgByteEn);
    wire logic [31:0] intrMerged = lane_merge({24'h000000, intLine_reg}, cfgWrData, cfgByteEn);
    wire logic [31:0] ioBarMerged = lane_merge(ioBar_reg, cfgWrData, cfgByteEn);
    wire logic [31:0] memBarMerged = lane_merge(memBar_reg, cfgWrData, cfgByteEn);

    // Low bits are forced so a write of all ones reads back the window size
    wire logic [31:0] ioBar_next = hitIoBar ?
        ((ioBarMerged & ~IOBAR_FIXED_MASK) | (IOBAR_RESET & IOBAR_FIXED_MASK)) : ioBar_reg; // [R22]
    wire logic [31:0] memBar_next = hitMemBar ?
        ((memBarMerged & ~MEMBAR_FIXED_MASK) | (MEMBAR_RESET & MEMBAR_FIXED_MASK)) : memBar_reg; // [R22]
    // Only byte 0 is storage in these dwords; upper lanes are dropped
    wire logic [7:0] cacheLine_next = hitMisc ? miscMerged[7:0] : cacheLine_reg; // [R02] [R21]
    wire logic [7:0] intLine_next = hitIntr ? intrMerged[7:0] : intLine_reg; // [R10] [R21]

    // Read-only fields change only by autoload, never by configuration writes
    wire logic [31:0] subsys_next = loadSubsys ? loadSubsysData : subsys_reg; // [R07] [R08] [R21]
    wire logic [7:0] capPtr_next = loadCapPtr ? loadCapPtrData : capPtr_reg; // [R09] [R21]
    // Revision, event clock and aux power stay fixed; the rest follows the load
    wire logic [PMC_WIDTH-1:0] pmLoadMasked = {loadPmCapData[15:5], PMC_AUX_POWER,
        PMC_EVENT_CLOCK, PMC_REVISION}; // [R14] [R15] [R16]
    wire logic [PMC_WIDTH-1:0] pmCap_next = loadPmCap ? pmLoadMasked : pmCap_reg; // [R17] [R18] [R19] [R20]

    // Read multiplexer; unmapped offsets inside the range return zero
    logic [31:0] rdData_next;
    always_comb begin
        case (cfgAddr)
            OFF_CLASS: rdData_next = {CLASS_BASE, CLASS_SUB, CLASS_PROG_IF, 8'h00}; // [R01]
            OFF_MISC: rdData_next = {8'h00, HEADER_TYPE_VALUE, LATENCY_TIMER_VALUE,
                                     cacheLine_reg}; // [R02] [R03] [R04]
            OFF_IOBAR: rdData_next = ioBar_reg; // [R05]
            OFF_MEMBAR: rdData_next = memBar_reg; // [R06]
            OFF_SUBSYS: rdData_next = subsys_reg; // [R07] [R08]
            OFF_CAPPTR: rdData_next = {24'h000000, capPtr_reg}; // [R09]
            OFF_INTR: rdData_next = {16'h0000, INT_PIN_VALUE, intLine_reg}; // [R10] [R11]
            OFF_PMCAP: rdData_next = {pmCap_reg, PM_NEXT_PTR, PM_CAP_ID}; // [R12] [R13]
            default: rdData_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cacheLine_reg <= CACHE_LINE_RESET; // [R02]
            intLine_reg <= INT_LINE_RESET; // [R10]
            ioBar_reg <= IOBAR_RESET; // [R05]
            memBar_reg <= MEMBAR_RESET; // [R06]
            subsys_reg <= {SUBSYS_DEVICE_INIT, SUBSYS_VENDOR_INIT}; // [R07] [R08]
            capPtr_reg <= CAP_PTR_DEFAULT; // [R09]
            pmCap_reg <= PMC_RESET; // [R14] [R15] [R16] [R17] [R18] [R19] [R20]
        end else begin
            cacheLine_reg <= cacheLine_next;
            intLine_reg <= intLine_next;
            ioBar_reg <= ioBar_next;
            memBar_reg <= memBar_next;
            subsys_reg <= subsys_next;
            capPtr_reg <= capPtr_next;
            pmCap_reg <= pmCap_next;
        end
    end

    // Read data registered: answer one cycle after the request
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg <= 32'h00000000;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg <= cfgRead ? rdData_next : rdData_reg;
            rdValid_reg <= cfgRead;
        end
    end

    assign cfgRdData = rdData_reg;
    assign cfgRdValid = rdValid_reg;
    assign ioWindowBase = ioBar_reg;
    assign memWindowBase = memBar_reg;
    assign interruptLine = intLine_reg;
endmodule : pucfg_header
`default_nettype wire

// ---- hw/pucfg_pkg.sv ----
// Package of offsets, field layouts and defaults for the UART function configuration header
`default_nettype none
package pucfg_pkg;
    // Dword byte offsets
    localparam logic [7:0] OFF_CLASS = 8'h08;
    localparam logic [7:0] OFF_MISC = 8'h0C;
    localparam logic [7:0] OFF_IOBAR = 8'h10;
    localparam logic [7:0] OFF_MEMBAR = 8'h14;
    localparam logic [7:0] OFF_SUBSYS = 8'h2C;
    localparam logic [7:0] OFF_CAPPTR = 8'h34;
    localparam logic [7:0] OFF_INTR = 8'h3C;
    localparam logic [7:0] OFF_PMCAP = 8'h80;
    // Class code bytes
    localparam logic [7:0] CLASS_PROG_IF = 8'h02;
    localparam logic [7:0] CLASS_SUB = 8'h00;
    localparam logic [7:0] CLASS_BASE = 8'h07;
    // Fixed and reset values
    localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
    localparam logic [7:0] LATENCY_TIMER_VALUE = 8'h00;
    localparam logic [7:0] HEADER_TYPE_VALUE = 8'h00;
    localparam logic [31:0] IOBAR_RESET = 32'h00000001;
    localparam logic [31:0] MEMBAR_RESET = 32'h00000000;
    localparam logic [7:0] INT_LINE_RESET = 8'h00;
    localparam logic [7:0] INT_PIN_VALUE = 8'h01;
    localparam logic [7:0] CAP_PTR_DEFAULT = 8'h80;
    localparam logic [7:0] PM_CAP_ID = 8'h01;
    localparam logic [7:0] PM_NEXT_PTR = 8'h8C;
    // Window sizes in bytes, and the BAR bits that stay fixed below the size boundary
    localparam int IO_WINDOW_BYTES = 64;
    localparam int MEM_WINDOW_BYTES = 4096;
    localparam logic [31:0] IOBAR_FIXED_MASK = 32'(IO_WINDOW_BYTES - 1);
    localparam logic [31:0] MEMBAR_FIXED_MASK = 32'(MEM_WINDOW_BYTES - 1);
    // Power management capability field layout within bits 31:16
    localparam int PMC_REV_LSB = 16;
    localparam int PMC_WIDTH = 16;
    localparam logic [2:0] PMC_REVISION = 3'h3;
    localparam logic PMC_EVENT_CLOCK = 1'b0;
    localparam logic PMC_AUX_POWER = 1'b1;
    localparam logic PMC_DSI_DEFAULT = 1'b0;
    localparam logic [2:0] PMC_AUX_CURRENT_DEFAULT = 3'h7;
    localparam logic PMC_D1_DEFAULT = 1'b1;
    localparam logic PMC_D2_DEFAULT = 1'b1;
    localparam logic [4:0] PMC_WAKE_DEFAULT = 5'h08;
    // Subsystem identifiers; the default values are arbitrary
    localparam logic [15:0] SUBSYS_VENDOR_DEFAULT = 16'h1A2B;
    localparam logic [15:0] SUBSYS_DEVICE_DEFAULT = 16'h3C4D;
endpackage : pucfg_pkg
`default_nettype wire

// ---- test/pucfg_header_props.sv ----
// Checker for the configuration header ports
`default_nettype none
module pucfg_header_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Config bus
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic [31:0] cfgRdData,
    input wire logic cfgRdValid,
    // Decoded state
    input wire logic [31:0] ioWindowBase,
    input wire logic [31:0] memWindowBase,
    input wire logic [7:0] interruptLine
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_cls; cfgRead && cfgAddr == 8'h08 |=> cfgRdValid && cfgRdData == 32'h07000200; endproperty
    a_cls: assert property (p_cls) else $error("class dword wrong");
    property p_misc; cfgRead && cfgAddr == 8'h0C |=> cfgRdData[31:8] == 24'h0; endproperty
    a_misc: assert property (p_misc) else $error("latency or header type wrong");
    property p_pm; cfgRead && cfgAddr == 8'h80 |=> cfgRdData[20:0] == 21'h138C01; endproperty
    a_pm: assert property (p_pm) else $error("power capability fixed bits wrong");
    property p_pin; cfgRead && cfgAddr == 8'h3C |=> cfgRdData == {16'h0, 8'h01, $past(interruptLine)}; endproperty
    a_pin: assert property (p_pin) else $error("interrupt dword wrong");
    property p_ilw; cfgWrite && cfgAddr == 8'h3C && cfgByteEn[0] |=> interruptLine == $past(cfgWrData[7:0]); endproperty
    a_ilw: assert property (p_ilw) else $error("interrupt line not written");
    property p_iow; cfgWrite && cfgAddr == 8'h10 && cfgByteEn == 4'hF |=> ioWindowBase == {$past(cfgWrData[31:6]), 6'h01}; endproperty
    a_iow: assert property (p_iow) else $error("io base write wrong");
    property p_iok; !(cfgWrite && cfgAddr == 8'h10) |=> $stable(ioWindowBase); endproperty
    a_iok: assert property (p_iok) else $error("io base moved");
    property p_mem; memWindowBase[11:0] == 12'h0; endproperty
    a_mem: assert property (p_mem) else $error("memory base low bits set");
    c_pm: cover property (cfgRead && cfgAddr == 8'h80);
    c_iow: cover property (cfgWrite && cfgAddr == 8'h10 && cfgByteEn == 4'hF);
    c_ilw: cover property (cfgWrite && cfgAddr == 8'h3C && cfgByteEn[0]);
endmodule : pucfg_header_chk
bind pucfg_header pucfg_header_chk u_chk (.mclk, .arst_n, .cfgRead, .cfgWrite, .cfgAddr,
    .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .ioWindowBase, .memWindowBase, .interruptLine);
`default_nettype wire

// ---- test/pucfg_rc_model.sv ----
// Root complex model issuing one configuration request per call
`default_nettype none
module pucfg_rc_model (
    // Clock and answer
    input wire logic mclk,
    input wire logic [31:0] cfgRdData,
    input wire logic cfgRdValid,
    // Requests
    output logic cfgRead = 1'b0,
    output logic cfgWrite = 1'b0,
    output logic [7:0] cfgAddr = 8'h00,
    output logic [3:0] cfgByteEn = 4'h0,
    output logic [31:0] cfgWrData = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released address and write data lines show the inverse so a stale value is never mistaken for a live one
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge mclk);
        cfgRead = 1'b1;
        cfgAddr = a;
        @(negedge mclk);
        cfgRead = 1'b0;
        cfgAddr = ~a;
        d = cfgRdValid ? cfgRdData : 'x;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge mclk);
        cfgWrite = 1'b1;
        cfgAddr = a;
        cfgWrData = d;
        cfgByteEn = b;
        @(negedge mclk);
        cfgWrite = 1'b0;
        cfgAddr = ~a;
        cfgWrData = ~d;
    endtask : wr
endmodule : pucfg_rc_model
`default_nettype wire

// ---- test/test_pucfg_header.sv ----
// Self-checking bench for the configuration header
`default_nettype none
module test_pucfg_header;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, arst_n = 1'b0, cfgRead, cfgWrite, cfgRdValid;
    logic loadSubsys = 1'b0, loadCapPtr = 1'b0, loadPmCap = 1'b0;
    logic [7:0] cfgAddr, interruptLine, loadCapPtrData = 8'h00;
    logic [3:0] cfgByteEn, b;
    logic [15:0] loadPmCapData = 16'h0;
    logic [31:0] cfgWrData, cfgRdData, ioWindowBase, memWindowBase, v, d, loadSubsysData = 32'h0;
    int fail_count = 0, total_checks = 0, seed = 32'h0B2EB359, i, k;
    logic [7:0] ad [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C, 8'h34, 8'h3C, 8'h80};
    logic [31:0] ex [8];
    pucfg_header dut (.mclk, .arst_n, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData,
        .cfgRdData, .cfgRdValid, .loadSubsys, .loadSubsysData, .loadCapPtr, .loadCapPtrData,
        .loadPmCap, .loadPmCapData, .ioWindowBase, .memWindowBase, .interruptLine);
    pucfg_rc_model rc (.mclk, .cfgRdData, .cfgRdValid, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn,
        .cfgWrData);
    always #2.5 mclk = ~mclk;
    // Only cache line, interrupt line and the base bits above each window size take writes
    function automatic logic [31:0] wexp(int j, logic [31:0] o, logic [31:0] w, logic [3:0] e);
        logic [31:0] n;
        n = (o & ~{{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}}) | (w & {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}});
        case (j)
            1, 6: return {o[31:8], n[7:0]};
            2: return {n[31:6], 6'h01};
            3: return {n[31:12], 12'h000};
            default: return o;
        endcase
    endfunction : wexp
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic rdall();
        for (int j = 0; j < 8; j++) begin
            rc.rd(ad[j], v);
            chk(v, ex[j]);
        end
        rc.rd(8'h40, v);
        chk(v, 32'h0);
    endtask : rdall
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
    initial begin
        ex = '{32'h07000200, 32'h0, 32'h1, 32'h0, {16'h3C4D, 16'h1A2B}, 32'h80, 32'h100,
            {5'b01000, 1'b1, 1'b1, 3'b111, 1'b0, 1'b1, 1'b0, 3'b011, 16'h8C01}};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        rdall();
        d = $random(seed);
        @(negedge mclk);
        {loadSubsys, loadCapPtr, loadPmCap} = 3'b111;
        {loadSubsysData, loadCapPtrData, loadPmCapData} = {d, d[7:0], d[31:16]};
        @(negedge mclk);
        {loadSubsys, loadCapPtr, loadPmCap} = 3'b000;
        {loadSubsysData, loadCapPtrData, loadPmCapData} = ~{d, d[7:0], d[31:16]};
        ex[4] = d;
        ex[5] = {24'h0, d[7:0]};
        ex[7] = {d[31:21], 5'h13, 16'h8C01};
        rc.rd(8'h80, v);
        chk(v, ex[7]);
        for (i = 0; i < 9; i++) begin
            rc.wr(i < 8 ? ad[i] : 8'h40, 32'hFFFFFFFF, 4'hF);
            if (i < 8) ex[i] = wexp(i, ex[i], 32'hFFFFFFFF, 4'hF);
        end
        rdall();
        chk(ioWindowBase, ex[2]);
        chk({24'h0, interruptLine}, ex[6] & 32'hFF);
        for (k = 0; k < 30; k++) begin
            i = $unsigned($random(seed)) % 8;
            d = $random(seed);
            b = 4'($random(seed));
            rc.wr(ad[i], d, b);
            ex[i] = wexp(i, ex[i], d, b);
            rc.rd(ad[i], v);
            chk(v, ex[i]);
        end
        chk(memWindowBase, ex[3]);
        conclude();
    end
endmodule : test_pucfg_header
`default_nettype wire
